// [shared/serial_prog_pkg.sv]
// Constants for the serial program/verify address logic
package serial_prog_pkg;
    // Address space seen while in program/verify mode
    localparam int          ADDR_W          = 14;
    localparam int          DATA_W          = 14;
    localparam int          CMD_W           = 6;
    localparam int          PHYS_W          = 11;
    localparam logic [13:0] PC_RESET        = 14'h0000;
    localparam logic [13:0] USER_TOP        = 14'h1fff;
    localparam logic [13:0] CFG_BASE        = 14'h2000;
    localparam logic [13:0] SPACE_TOP       = 14'h3fff;
    localparam int          CFG_SEL_BIT     = 13;
    localparam logic [7:0]  ID_LAST_OFS     = 8'h03;

    // User memory size straps and their address masks
    localparam logic [1:0]  SIZE_HALF_K     = 2'h0;
    localparam logic [1:0]  SIZE_ONE_K      = 2'h1;
    localparam logic [1:0]  SIZE_TWO_K      = 2'h2;
    localparam logic [10:0] MASK_HALF_K     = 11'h1ff;
    localparam logic [10:0] MASK_ONE_K      = 11'h3ff;
    localparam logic [10:0] MASK_TWO_K      = 11'h7ff;

    // Serial command codes
    localparam logic [5:0]  CMD_LOAD_CFG    = 6'h00;
    localparam logic [5:0]  CMD_LOAD_DATA   = 6'h02;
    localparam logic [5:0]  CMD_READ_DATA   = 6'h04;
    localparam logic [5:0]  CMD_INC_ADDR    = 6'h06;
    localparam logic [5:0]  CMD_BEGIN_PROG  = 6'h08;
    localparam logic [5:0]  CMD_END_PROG    = 6'h0e;

    // Bit positions within a command or data word, counted in clock edges
    localparam logic [3:0]  CMD_LAST_FALL   = 4'h5;
    localparam logic [3:0]  DATA_FIRST_EDGE = 4'h1;
    localparam logic [3:0]  DATA_LAST_EDGE  = 4'he;
    localparam logic [3:0]  WORD_LAST_EDGE  = 4'hf;

    // Read output delay after the rising serial clock edge
    localparam int          CLK_PERIOD_NS   = 50;
    localparam int          READ_DELAY_NS   = 200;
    localparam logic [2:0]  READ_DELAY_CYC  =
        3'((READ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage

// [hdl/serial_program_address_map.sv]
// Program/verify mode serial front end and program counter address map
`timescale 1ns/10ps
module serial_program_address_map (
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        master_clear_pin_i,
    input  wire logic        serial_clock_pin_i,
    input  wire logic        serial_data_pin_i,
    output logic             serial_data_o,
    output logic             serial_data_oe_o,
    input  wire logic [1:0]  mem_size_i,
    input  wire logic [13:0] mem_rdata_i,
    output logic [10:0]      mem_raddr_o,
    output logic             mem_rcfg_o,
    output logic             mem_rid_o,
    output logic             mem_wvalid_o,
    input  wire logic        mem_wready_i,
    output logic [10:0]      mem_waddr_o,
    output logic             mem_wcfg_o,
    output logic [13:0]      mem_wdata_o,
    output logic [13:0]      program_counter_o
);
    typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_LOAD, ST_READ, ST_PUSH} state_t;

    // Advance with the wrap of the current half; the top bit is never touched
    function automatic logic [13:0] pc_advance(input logic [13:0] pc);
        pc_advance = {pc[serial_prog_pkg::CFG_SEL_BIT], 13'(pc[12:0] + 13'h0001)};
    endfunction

    // Physical word address for the memory arrays
    function automatic logic [10:0] phys_addr(input logic [13:0] pc, input logic [1:0] size);
        logic [10:0] mask;
        mask = serial_prog_pkg::MASK_TWO_K;
        unique case (size)
            serial_prog_pkg::SIZE_HALF_K: mask = serial_prog_pkg::MASK_HALF_K;
            serial_prog_pkg::SIZE_ONE_K:  mask = serial_prog_pkg::MASK_ONE_K;
            default:                      mask = serial_prog_pkg::MASK_TWO_K;
        endcase
        if (pc[serial_prog_pkg::CFG_SEL_BIT])
            phys_addr = {3'h0, pc[7:0]};
        else
            phys_addr = pc[10:0] & mask;
    endfunction

    logic [2:0]  master_clear_pin_sync;
    logic [2:0]  sclk_sync;
    logic [1:0]  sdat_sync;
    state_t      state,        next_state;
    logic [13:0] program_counter, next_program_counter;
    logic [5:0]  cmd,          next_cmd;
    logic [3:0]  fall_cnt,     next_fall_cnt;
    logic [3:0]  rise_cnt,     next_rise_cnt;
    logic [13:0] load_shift,   next_load_shift;
    logic [13:0] data_word,    next_data_word;
    logic [13:0] read_shift,   next_read_shift;
    logic [2:0]  dly,          next_dly;
    logic        sdo,          next_sdo;
    logic        sdo_en,       next_sdo_en;
    logic [10:0] raddr,        next_raddr;
    logic        rcfg,         next_rcfg;
    logic        rid,          next_rid;
    logic [25:0] head,         next_head;
    logic        head_valid,   next_head_valid;
    logic [25:0] spare,        next_spare;
    logic        spare_valid,  next_spare_valid;
    logic        mode,         sclk_rise,  sclk_fall,  sdi;
    logic        do_push,      do_pop,     do_inc,     do_load_cfg;
    logic [25:0] push_entry;

    // Pin synchronisers; the first stage feeds only the second
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            master_clear_pin_sync <= 3'h0;
            sclk_sync <= 3'h0;
            sdat_sync <= 2'h0;
        end else begin
            master_clear_pin_sync <= {master_clear_pin_sync[1:0], master_clear_pin_i};
            sclk_sync <= {sclk_sync[1:0], serial_clock_pin_i};
            sdat_sync <= {sdat_sync[0], serial_data_pin_i};
        end
    end

    assign mode       = master_clear_pin_sync[1];
    assign sclk_rise  = sclk_sync[1] & ~sclk_sync[2];
    assign sclk_fall  = ~sclk_sync[1] & sclk_sync[2];
    assign sdi        = sdat_sync[1];
    assign push_entry = {rcfg, raddr, data_word};

    // Serial command engine, program counter and two-entry write buffer
    always_comb begin
        next_state           = state;
        next_program_counter = program_counter;
        next_cmd             = cmd;
        next_fall_cnt        = fall_cnt;
        next_rise_cnt        = rise_cnt;
        next_load_shift      = load_shift;
        next_data_word       = data_word;
        next_read_shift      = read_shift;
        next_dly             = dly;
        next_sdo             = sdo;
        next_sdo_en          = sdo_en;
        do_push              = 1'b0;
        do_inc               = 1'b0;
        do_load_cfg          = 1'b0;
        if (!mode) begin
            // Dropping master clear is the only way back to user memory
            next_state           = ST_IDLE;
            next_program_counter = serial_prog_pkg::PC_RESET;
            next_fall_cnt        = 4'h0;
            next_rise_cnt        = 4'h0;
            next_dly             = 3'h0;
            next_sdo_en          = 1'b0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    next_state           = ST_CMD;
                    next_program_counter = serial_prog_pkg::PC_RESET;
                    next_fall_cnt        = 4'h0;
                end
                ST_CMD: begin
                    if (sclk_fall) begin
                        next_cmd      = {sdi, cmd[5:1]};
                        next_fall_cnt = 4'(fall_cnt + 4'h1);
                        if (fall_cnt == serial_prog_pkg::CMD_LAST_FALL) begin
                            next_fall_cnt = 4'h0;
                            unique case (next_cmd)
                                serial_prog_pkg::CMD_LOAD_CFG: begin
                                    do_load_cfg          = 1'b1;
                                    next_program_counter = serial_prog_pkg::CFG_BASE;
                                    next_state           = ST_LOAD;
                                end
                                serial_prog_pkg::CMD_LOAD_DATA: next_state = ST_LOAD;
                                serial_prog_pkg::CMD_READ_DATA: begin
                                    next_read_shift = mem_rdata_i;
                                    next_rise_cnt   = 4'h0;
                                    next_state      = ST_READ;
                                end
                                serial_prog_pkg::CMD_INC_ADDR: begin
                                    do_inc               = 1'b1;
                                    next_program_counter = pc_advance(program_counter);
                                end
                                serial_prog_pkg::CMD_BEGIN_PROG: next_state = ST_PUSH;
                                // End programming and unknown codes change nothing here
                                default: next_state = ST_CMD;
                            endcase
                        end
                    end
                end
                ST_LOAD: begin
                    if (sclk_fall) begin
                        next_fall_cnt = 4'(fall_cnt + 4'h1);
                        if (fall_cnt >= serial_prog_pkg::DATA_FIRST_EDGE &&
                            fall_cnt <= serial_prog_pkg::DATA_LAST_EDGE)
                            next_load_shift = {sdi, load_shift[13:1]};
                        if (fall_cnt == serial_prog_pkg::WORD_LAST_EDGE) begin
                            next_fall_cnt  = 4'h0;
                            next_data_word = load_shift;
                            next_state     = ST_CMD;
                        end
                    end
                end
                ST_READ: begin
                    // Pending bit goes out once the delay has run down
                    if (dly != 3'h0) begin
                        next_dly = 3'(dly - 3'h1);
                        if (dly == 3'h1) begin
                            next_sdo_en     = 1'b1;
                            next_sdo        = read_shift[0];
                            next_read_shift = {1'b0, read_shift[13:1]};
                        end
                    end
                    if (sclk_rise) begin
                        next_rise_cnt = 4'(rise_cnt + 4'h1);
                        if (rise_cnt >= serial_prog_pkg::DATA_FIRST_EDGE &&
                            rise_cnt <= serial_prog_pkg::DATA_LAST_EDGE)
                            next_dly = serial_prog_pkg::READ_DELAY_CYC;
                        if (rise_cnt == serial_prog_pkg::WORD_LAST_EDGE) begin
                            next_dly    = 3'h0;
                            next_sdo_en = 1'b0;
                        end
                    end
                    if (sclk_fall) begin
                        next_fall_cnt = 4'(fall_cnt + 4'h1);
                        if (fall_cnt == serial_prog_pkg::WORD_LAST_EDGE) begin
                            next_fall_cnt = 4'h0;
                            next_rise_cnt = 4'h0;
                            next_sdo_en   = 1'b0;
                            next_dly      = 3'h0;
                            next_state    = ST_CMD;
                        end
                    end
                end
                ST_PUSH: begin
                    // A full buffer stalls the engine instead of dropping the word
                    do_push = ~spare_valid;
                    if (do_push)
                        next_state = ST_CMD;
                end
            endcase
        end
        // Read address registered alongside the counter; aliased blocks repeat the id words
        next_raddr = phys_addr(next_program_counter, mem_size_i);
        next_rcfg  = next_program_counter[serial_prog_pkg::CFG_SEL_BIT];
        next_rid   = next_rcfg &&
                     (next_program_counter[7:0] <= serial_prog_pkg::ID_LAST_OFS);
        // Two-entry buffer: head drives the ports, spare catches a stalled push
        do_pop           = head_valid & mem_wready_i;
        next_head        = head;
        next_head_valid  = head_valid;
        next_spare       = spare;
        next_spare_valid = spare_valid;
        if (do_pop) begin
            if (spare_valid) begin
                next_head        = spare;
                next_spare_valid = do_push;
                next_spare       = push_entry;
            end else begin
                next_head_valid = do_push;
                next_head       = push_entry;
            end
        end else if (do_push) begin
            if (head_valid) begin
                next_spare_valid = 1'b1;
                next_spare       = push_entry;
            end else begin
                next_head_valid = 1'b1;
                next_head       = push_entry;
            end
        end
    end

    // State registers
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state           <= ST_IDLE;
            program_counter <= serial_prog_pkg::PC_RESET;
            cmd             <= 6'h00;
            fall_cnt        <= 4'h0;
            rise_cnt        <= 4'h0;
            load_shift      <= 14'h0000;
            data_word       <= 14'h0000;
            read_shift      <= 14'h0000;
            dly             <= 3'h0;
            sdo             <= 1'b0;
            sdo_en          <= 1'b0;
            raddr           <= 11'h000;
            rcfg            <= 1'b0;
            rid             <= 1'b0;
            head            <= 26'h0000000;
            head_valid      <= 1'b0;
            spare           <= 26'h0000000;
            spare_valid     <= 1'b0;
        end else begin
            state           <= next_state;
            program_counter <= next_program_counter;
            cmd             <= next_cmd;
            fall_cnt        <= next_fall_cnt;
            rise_cnt        <= next_rise_cnt;
            load_shift      <= next_load_shift;
            data_word       <= next_data_word;
            read_shift      <= next_read_shift;
            dly             <= next_dly;
            sdo             <= next_sdo;
            sdo_en          <= next_sdo_en;
            raddr           <= next_raddr;
            rcfg            <= next_rcfg;
            rid             <= next_rid;
            head            <= next_head;
            head_valid      <= next_head_valid;
            spare           <= next_spare;
            spare_valid     <= next_spare_valid;
        end
    end

    assign serial_data_o     = sdo;
    assign serial_data_oe_o  = sdo_en;
    assign mem_raddr_o       = raddr;
    assign mem_rcfg_o        = rcfg;
    assign mem_rid_o         = rid;
    assign mem_wvalid_o      = head_valid;
    assign mem_wcfg_o        = head[25];
    assign mem_waddr_o       = head[24:14];
    assign mem_wdata_o       = head[13:0];
    assign program_counter_o = program_counter;
    // Helper: cycles since the last synchronised rising clock edge
    logic [7:0] since_rise;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || sclk_rise)
            since_rise <= 8'h00;
        else if (since_rise != 8'hff)
            since_rise <= 8'(since_rise + 8'h01);
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    user_wrap_a: assert property (do_inc && program_counter == 14'h1fff
        |=> program_counter == 14'h0000) else $error("user half did not wrap to zero");
    cfg_wrap_a: assert property (do_inc && program_counter == 14'h3fff
        |=> program_counter == 14'h2000) else $error("config half did not wrap to base");
    cfg_sticky_a: assert property (program_counter[13] && mode && master_clear_pin_sync[2]
        |=> program_counter[13] || !mode) else $error("counter left config memory");
    cfg_alias_a: assert property (program_counter[13] |-> mem_rcfg_o &&
        mem_raddr_o == {3'h0, program_counter[7:0]}) else $error("config address not aliased");
    user_size_a: assert property (!program_counter[13] && mem_size_i == 2'h0
        |=> mem_raddr_o[10:9] == 2'h0) else $error("half-kiloword access out of range");
    load_cfg_a: assert property (do_load_cfg |=> program_counter == 14'h2000 &&
        state == ST_LOAD) else $error("load configuration misplaced counter");
    entry_clear_a: assert property ($rose(mode) |=> ##1 program_counter == 14'h0000 &&
        state == ST_CMD) else $error("mode entry did not clear counter");
    read_delay_a: assert property ($rose(serial_data_oe_o) |-> since_rise >= 8'h04)
        else $error("read data driven too early");
    oe_release_a: assert property (state == ST_READ && sclk_rise && rise_cnt == 4'hf
        |=> !serial_data_oe_o) else $error("data pin not released after last rise");
    id_window_a: assert property (mem_rid_o |-> mem_rcfg_o && mem_raddr_o <= 11'h003)
        else $error("identification flag outside id words");
    load_cfg_c: cover property (do_load_cfg);
    read_word_c: cover property (state == ST_READ && sclk_fall && fall_cnt == 4'hf);
    buffer_full_c: cover property (spare_valid && !mem_wready_i);
    user_wrap_c: cover property (do_inc && program_counter == 14'h1fff);
endmodule

// [testbench/prog_partner.sv]
// Programmer and memory array model for the serial program/verify port
`timescale 1ns/10ps
module prog_partner #(
    parameter int GAP_CYC = 20000
) (
    input  wire logic        clk_i,
    input  wire logic        dev_data_i,
    input  wire logic        dev_oe_i,
    input  wire logic [10:0] raddr_i,
    input  wire logic        rcfg_i,
    output logic             sclk_o,
    output logic             sdata_o,
    output logic [13:0]      rdata_o,
    output logic             wready_o
);
    logic drv   = 1'b1;
    logic dval  = 1'b0;
    logic last  = 1'b0;
    logic stall = 1'b0;
    initial sclk_o = 1'b0;
    // Released line toggles every cycle so a stale bit never reads as good
    assign sdata_o = dev_oe_i ? dev_data_i : (drv ? dval : ~last);
    always @(negedge clk_i) begin
        last <= sdata_o;
    end
    // Array word carries its own address, so every read is predictable
    assign rdata_o  = {rcfg_i, 2'h2, raddr_i};
    assign wready_o = ~stall;
    task automatic half();
        repeat (4) @(negedge clk_i);
    endtask
    // Bit set on the rise and held past the fall where the device latches it
    task automatic shift(input logic [15:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            sclk_o = 1'b1;
            drv = 1'b1;
            dval = v[i];
            half();
            sclk_o = 1'b0;
            half();
        end
        drv = 1'b0;
        repeat (GAP_CYC) @(negedge clk_i);
    endtask
    task automatic command(input logic [5:0] code);
        shift({10'h000, code}, 6);
    endtask
    task automatic word_out(input logic [13:0] w);
        shift({1'b0, w, 1'b0}, 16);
    endtask
    // Each bit is sampled just before the following rise
    task automatic read_word(output logic [13:0] w, output logic oe_first,
                             output logic oe_end);
        drv = 1'b0;
        for (int i = 1; i <= 16; i++) begin
            sclk_o = 1'b1;
            half();
            sclk_o = 1'b0;
            half();
            if (i == 1) oe_first = dev_oe_i;
            else if (i < 16) w[i - 2] = sdata_o;
            else oe_end = dev_oe_i;
        end
        repeat (GAP_CYC) @(negedge clk_i);
    endtask
endmodule

// [testbench/tb_top.sv]
// Self-checking bench for the program/verify address map
`timescale 1ns/10ps
`define check(nm, exp, got) begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("unexpected %s expected %h seen %h", nm, exp, got); \
    end \
end
module tb_top;
    // Entry hold and gaps shortened; the block does not time them
    localparam int ENTRY_CYC = 40;
    logic        clk_i     = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        master_clear_pin      = 1'b0;
    logic [1:0]  mem_size  = serial_prog_pkg::SIZE_HALF_K;
    logic        sclk, sdata, dout, doe, rcfg, rid, wvalid, wready, wcfg;
    logic [13:0] rdata, wdata, pc, word;
    logic [10:0] raddr, waddr;
    logic        oe_a, oe_b;
    int          mismatches  = 0;
    int          comparisons = 0;
    always #25 clk_i = ~clk_i;
    serial_program_address_map dut (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .master_clear_pin_i(master_clear_pin),
        .serial_clock_pin_i(sclk), .serial_data_pin_i(sdata),
        .serial_data_o(dout), .serial_data_oe_o(doe), .mem_size_i(mem_size),
        .mem_rdata_i(rdata), .mem_raddr_o(raddr), .mem_rcfg_o(rcfg),
        .mem_rid_o(rid), .mem_wvalid_o(wvalid), .mem_wready_i(wready),
        .mem_waddr_o(waddr), .mem_wcfg_o(wcfg), .mem_wdata_o(wdata),
        .program_counter_o(pc));
    prog_partner #(.GAP_CYC(16)) pp (
        .clk_i(clk_i), .dev_data_i(dout), .dev_oe_i(doe), .raddr_i(raddr),
        .rcfg_i(rcfg), .sclk_o(sclk), .sdata_o(sdata), .rdata_o(rdata),
        .wready_o(wready));
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Data pin held low while master clear rises
    task automatic enter_mode();
        pp.drv = 1'b1;
        pp.dval = 1'b0;
        master_clear_pin = 1'b0;
        repeat (4) @(negedge clk_i);
        master_clear_pin = 1'b1;
        repeat (ENTRY_CYC) @(negedge clk_i);
        `check("counter", 14'h0000, pc)
        `check("cfg select", 1'b0, rcfg)
    endtask
    task automatic user_wrap();
        for (int i = 0; i < 512; i++) pp.command(serial_prog_pkg::CMD_INC_ADDR);
        `check("counter", 14'h0200, pc)
        `check("user phys", 11'h000, raddr)
        pp.command(serial_prog_pkg::CMD_READ_DATA);
        pp.read_word(word, oe_a, oe_b);
        `check("read word", 14'h1000, word)
        `check("early drive", 1'b0, oe_a)
        `check("release", 1'b0, oe_b)
        // Larger size straps keep more counter bits, so 0x200 no longer folds to zero
        mem_size = serial_prog_pkg::SIZE_ONE_K;
        repeat (2) @(negedge clk_i);
        `check("one-k phys", 11'h200, raddr)
        pp.command(serial_prog_pkg::CMD_READ_DATA);
        pp.read_word(word, oe_a, oe_b);
        `check("one-k read", 14'h1200, word)
        mem_size = serial_prog_pkg::SIZE_TWO_K;
        repeat (2) @(negedge clk_i);
        `check("two-k phys", 11'h200, raddr)
    endtask
    // Write held by a stalled array, then aliasing through 256 increments
    task automatic cfg_alias();
        pp.stall = 1'b1;
        pp.command(serial_prog_pkg::CMD_LOAD_CFG);
        pp.word_out(14'h3f85);
        `check("counter", serial_prog_pkg::CFG_BASE, pc)
        `check("id select", 1'b1, rid)
        pp.command(serial_prog_pkg::CMD_BEGIN_PROG);
        `check("write valid", 1'b1, wvalid)
        `check("write addr", 11'h000, waddr)
        `check("write cfg", 1'b1, wcfg)
        `check("write data", 14'h3f85, wdata)
        // A second word waits in the spare slot behind the stalled head
        pp.command(serial_prog_pkg::CMD_LOAD_CFG);
        pp.word_out(14'h3f8a);
        pp.command(serial_prog_pkg::CMD_BEGIN_PROG);
        `check("held data", 14'h3f85, wdata)
        pp.stall = 1'b0;
        @(negedge clk_i);
        `check("second valid", 1'b1, wvalid)
        `check("second data", 14'h3f8a, wdata)
        repeat (2) @(negedge clk_i);
        `check("write drained", 1'b0, wvalid)
        for (int i = 1; i <= 256; i++) begin
            pp.command(serial_prog_pkg::CMD_INC_ADDR);
            `check("cfg bit", 1'b1, pc[13])
            if (i == 4) `check("id select", 1'b0, rid)
        end
        `check("counter", 14'h2100, pc)
        `check("cfg phys", 11'h000, raddr)
        `check("id alias", 1'b1, rid)
        pp.command(serial_prog_pkg::CMD_READ_DATA);
        pp.read_word(word, oe_a, oe_b);
        `check("cfg read", 14'h3000, word)
    endtask
    // Loading data keeps the config half; only leaving the mode returns
    task automatic reenter();
        pp.command(serial_prog_pkg::CMD_LOAD_DATA);
        pp.word_out(14'h0155);
        `check("cfg bit", 1'b1, pc[13])
        enter_mode();
    endtask
    initial begin
        repeat (2) @(negedge clk_i);
        sys_rst_i = 1'b0;
        enter_mode();
        user_wrap();
        cfg_alias();
        reenter();
        finish_test();
    end
    // Watchdog cuts a hang short
    initial begin
        repeat (90000) @(negedge clk_i);
        mismatches++;
        finish_test();
    end
endmodule
